// >>> gpc_pkg.sv
// package for the gpio control word block: offsets, fields, reset values
// What this block does
// - power loss or low-power reset clears the control word to zero
// - read at the control word location returns current gpio state
// - layout: enables 15:12, reserved 11:8, mask 7:4, input 3, drives 2:0
// - input enable one samples the input pin into the read data bit
// - input enable changes only when mask bit 7 is written one
// - output enable zero tri-states pin, one drives its drive value
// - output enable changes only when its mask bit 6..4 is one
// - mask bit 7 loads input enable and input data together
// - mask bits 6..4 load enable and drive value of pins 2..0
// - mask bits always read back as zero
// - input disabled: bit 3 reads the last loaded data value
// - input enabled: bit 3 reads live pin, written value ignored
// - input data bit loads only when mask bit 7 is one
// - output disabled: drive bit reads zero, pin unaffected
// - output enabled: drive zero gives low, one gives high
// - drive value bits change only with their mask bit set
// - enable bits read back their current settings
// - reserved bits 11:8 always read zero
package gpc_pkg;
	localparam logic [11:0] GPC_CTRL_ADDR   = 12'hf00;
	localparam logic [15:0] GPC_CTRL_RESET  = 16'h0000;
	localparam int          GPC_EN_LSB      = 12;
	localparam int          GPC_MASK_LSB    = 4;
	localparam int          GPC_IN_EN_BIT   = 15;
	localparam int          GPC_IN_MASK_BIT = 7;
	localparam int          GPC_IN_DAT_BIT  = 3;
	localparam int          GPC_OUT_PINS    = 3;
	localparam int          GPC_SYNC_LEN    = 3;
endpackage : gpc_pkg

// >>> gpc_properties.sv
// port checker for the gpio control word
module gpc_chk
	import gpc_pkg::*;
(
	input wire logic SYS_CLK_I, RSTN_I, LOW_POWER_RST_I, WR_EN_I, RD_EN_I,
	input wire logic IRQ_LINE_I, RD_VALID_O, RD_HIT_O,
	input wire logic [11:0] WORD_LOCATION_I,
	input wire logic [15:0] WR_DATA_I, RD_DATA_O,
	input wire logic [2:0]  GP_OUT_PIN_O, GP_OUT_PIN_OE_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	wire wr = WR_EN_I && !LOW_POWER_RST_I &&
		WORD_LOCATION_I == GPC_CTRL_ADDR;
	a_rv: assert property (p_rv) else $error("no read valid");
	property p_rv;
		RD_EN_I && !LOW_POWER_RST_I |=> RD_VALID_O;
	endproperty
	a_rsv: assert property (p_rsv) else $error("bits 11:4 set");
	property p_rsv;
		RD_VALID_O |-> RD_DATA_O[11:4] == 8'h00;
	endproperty
	a_oe: assert property (p_oe) else $error("pin 0 enable");
	property p_oe;
		wr && WR_DATA_I[4] |=>
			GP_OUT_PIN_OE_O[0] == $past(WR_DATA_I[12]);
	endproperty
	a_keep: assert property (p_keep) else $error("pins moved");
	property p_keep;
		!wr && !LOW_POWER_RST_I |=>
			$stable({GP_OUT_PIN_O, GP_OUT_PIN_OE_O});
	endproperty
	a_tri: assert property (p_tri) else $error("undriven pin high");
	property p_tri;
		(GP_OUT_PIN_O & ~GP_OUT_PIN_OE_O) == 3'h0;
	endproperty
	a_lp: assert property (p_lp) else $error("no clear");
	property p_lp;
		LOW_POWER_RST_I |=> {GP_OUT_PIN_O, GP_OUT_PIN_OE_O} == 6'h00;
	endproperty
	a_drv: assert property (p_drv) else $error("pin 2 level");
	property p_drv;
		wr && WR_DATA_I[6] && WR_DATA_I[14] |=>
			GP_OUT_PIN_O[2] == $past(WR_DATA_I[2]);
	endproperty
	a_miss: assert property (p_miss) else $error("unmapped read");
	property p_miss;
		RD_EN_I && WORD_LOCATION_I != GPC_CTRL_ADDR |=>
			!RD_HIT_O && RD_DATA_O == 16'h0000;
	endproperty
endmodule : gpc_chk
bind gpc_top gpc_chk u_chk (.*);

// >>> gpc_rdr.sv
// reader model: one-cycle strobes launched on the falling edge
module gpc_rdr (
	input  wire logic        clk,
	output logic             we = 0,
	output logic             re = 0,
	output logic      [11:0] a = 0,
	output logic      [15:0] d = 0,
	input  wire logic [15:0] q
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic xfer(input logic r, input logic [11:0] ad,
		input logic [15:0] dt, output logic [15:0] o);
		@(negedge clk);
		we = !r;
		re = r;
		a = ad;
		d = dt & 16'hf0ff;
		@(negedge clk);
		we = 0;
		re = 0;
		d = ~d;
		o = q;
	endtask : xfer
endmodule : gpc_rdr

// >>> gpc_sync.sv
// three-flop synchroniser with agreement filter for one pin input
module gpc_sync
	import gpc_pkg::*;
(
	input  wire logic SYS_CLK_I,
	input  wire logic RSTN_I,
	input  wire logic D_I,
	output logic      Q_O
);
	typedef struct packed {
		logic [GPC_SYNC_LEN-1:0] ff;
		logic                    q;
	} gpc_sync_st_t;

	gpc_sync_st_t s_q;
	gpc_sync_st_t s_d;

	// first flop feeds only the second; change taken once 2nd and 3rd agree
	always_comb begin
		s_d    = s_q;
		s_d.ff = {s_q.ff[GPC_SYNC_LEN-2:0], D_I};
		if (s_q.ff[1] == s_q.ff[2]) begin
			s_d.q = s_q.ff[2];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign Q_O = s_q.q;
endmodule : gpc_sync

// >>> gpc_top.sv
// gpio control word: memory-command write/read port and pin drivers
module gpc_top
	import gpc_pkg::*;
(
	input  wire logic        SYS_CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        LOW_POWER_RST_I,
	input  wire logic        WR_EN_I,
	input  wire logic        RD_EN_I,
	input  wire logic [11:0] WORD_LOCATION_I,
	input  wire logic [15:0] WR_DATA_I,
	output logic      [15:0] RD_DATA_O,
	output logic             RD_VALID_O,
	output logic             RD_HIT_O,
	input  wire logic        IRQ_LINE_I,
	output logic      [2:0]  GP_OUT_PIN_O,
	output logic      [2:0]  GP_OUT_PIN_OE_O
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                    in_en;
		logic                    irq_line_value;
		logic [GPC_OUT_PINS-1:0] out_en;
		logic [GPC_OUT_PINS-1:0] pin_drive_values;
		logic [15:0]             rd_data;
		logic                    rd_valid;
		logic                    rd_hit;
		logic [GPC_OUT_PINS-1:0] pin_q;
		logic [GPC_OUT_PINS-1:0] pin_oe_q;
	} gpc_st_t;

	gpc_st_t st_q;
	gpc_st_t st_d;
	logic    irq_sync;
	logic    hit;

	gpc_sync u_irq_sync (
		.SYS_CLK_I (SYS_CLK_I),
		.RSTN_I    (RSTN_I),
		.D_I       (IRQ_LINE_I),
		.Q_O       (irq_sync)
	);

	// ----------------------------------------------------------------
	// read image of the control word
	// ----------------------------------------------------------------
	function automatic logic [15:0] read_word(input gpc_st_t s,
	                                          input logic    live);
		logic [15:0] w;
		w = GPC_CTRL_RESET;
		w[GPC_IN_EN_BIT] = s.in_en;
		w[GPC_EN_LSB +: GPC_OUT_PINS] = s.out_en;
		w[GPC_IN_DAT_BIT] = s.in_en ? live : s.irq_line_value;
		w[GPC_OUT_PINS-1:0] = s.pin_drive_values & s.out_en;
		return w;
	endfunction : read_word

	assign hit = (WORD_LOCATION_I == GPC_CTRL_ADDR);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d          = st_q;
		st_d.rd_valid = RD_EN_I;
		st_d.rd_hit   = RD_EN_I & hit;
		if (RD_EN_I) begin
			// unmapped locations answer zero; other banks are elsewhere
			st_d.rd_data = hit ? read_word(st_q, irq_sync) : '0;
		end
		if (WR_EN_I && hit) begin
			// one register update: every masked field lands together
			if (WR_DATA_I[GPC_IN_MASK_BIT]) begin
				st_d.in_en          = WR_DATA_I[GPC_IN_EN_BIT];
				st_d.irq_line_value = WR_DATA_I[GPC_IN_DAT_BIT];
			end
			for (int n = 0; n < GPC_OUT_PINS; n++) begin
				if (WR_DATA_I[GPC_MASK_LSB + n]) begin
					st_d.out_en[n] = WR_DATA_I[GPC_EN_LSB + n];
					st_d.pin_drive_values[n] = WR_DATA_I[n];
				end
			end
		end
		// pin level registered already gated, so no logic sits on the pad
		st_d.pin_q    = st_d.pin_drive_values & st_d.out_en;
		st_d.pin_oe_q = st_d.out_en;
		if (LOW_POWER_RST_I) begin
			// low-power detection wipes all top state but not the irq synchroniser, reader must rewrite
			st_d = '0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign RD_DATA_O       = st_q.rd_data;
	assign RD_VALID_O      = st_q.rd_valid;
	assign RD_HIT_O        = st_q.rd_hit;
	assign GP_OUT_PIN_O    = st_q.pin_q;
	assign GP_OUT_PIN_OE_O = st_q.pin_oe_q;
endmodule : gpc_top

// >>> testbench.sv
// randomised bench for the gpio control word
module testbench;
	import gpc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, lp = 0, irq = 0, we, re;
	logic [11:0] a;
	logic [15:0] d, q, r, w;
	logic [2:0]  pin, oe;
	logic [3:0]  en = 0, dat = 0;
	int fail_count = 0, cmp_count = 0;
	always #2 clk = ~clk;
	gpc_top dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .LOW_POWER_RST_I(lp),
		.WR_EN_I(we), .RD_EN_I(re), .WORD_LOCATION_I(a), .WR_DATA_I(d),
		.RD_DATA_O(q), .RD_VALID_O(), .RD_HIT_O(), .IRQ_LINE_I(irq),
		.GP_OUT_PIN_O(pin), .GP_OUT_PIN_OE_O(oe));
	gpc_rdr rdr (.clk(clk), .we(we), .re(re), .a(a), .d(d), .q(q));
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_sim;
		if (fail_count == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	initial begin
		#20000;
		fail_count++;
		end_sim;
	end
	initial begin
		void'($urandom(32'h49fa392b));
		repeat (10) @(negedge clk);
		rstn = 1;
		for (int i = 0; i < 40; i++) begin
			w = i == 0 ? 16'hf0ff : i == 1 ? 16'h00f8 : 16'($urandom);
			irq = 1'($urandom);
			repeat (6) @(negedge clk);
			rdr.xfer(0, GPC_CTRL_ADDR, w, r);
			// only masked pairs move
			for (int b = 0; b < 4; b++) if (w[4 + b]) begin
				en[b] = w[12 + b];
				dat[b] = w[b];
			end
			chk("pins", {oe, pin}, {en[2:0], dat[2:0] & en[2:0]});
			rdr.xfer(1, GPC_CTRL_ADDR, 16'h0000, r);
			chk("word", r, {en, 8'h00, en[3] ? irq : dat[3],
				dat[2:0] & en[2:0]});
		end
		rdr.xfer(1, 12'hf01, 16'h0000, r);
		chk("unmapped", r, 16'h0000);
		rdr.xfer(0, GPC_CTRL_ADDR, 16'hf0ff, r);
		@(negedge clk);
		lp = 1;
		@(negedge clk);
		lp = 0;
		rdr.xfer(1, GPC_CTRL_ADDR, 16'h0000, r);
		chk("cleared", r, GPC_CTRL_RESET);
		// power loss in mid-run: async reset, then reader rewrites
		rdr.xfer(0, GPC_CTRL_ADDR, 16'hf0ff, r);
		@(negedge clk);
		rstn = 0;
		@(negedge clk);
		rstn = 1;
		rdr.xfer(1, GPC_CTRL_ADDR, 16'h0000, r);
		chk("power loss", r, GPC_CTRL_RESET);
		rdr.xfer(0, GPC_CTRL_ADDR, 16'h1010, r);
		chk("rewrite", {oe, pin}, 16'h0008);
		end_sim;
	end
endmodule : testbench
